// [dcsa_pkg.sv]
// Constants for the drive command source arbiter
//==============================================================
package dcsa_pkg;

	//==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_SOURCE  = 8'h04;
	localparam logic [7:0] OFS_FREQCFG = 8'h08;
	localparam logic [7:0] OFS_BRAKE   = 8'h0c;
	localparam logic [7:0] OFS_TERMFN  = 8'h10;
	localparam logic [7:0] OFS_STATUS  = 8'h14;

	//==========================================================
	// Field positions
	localparam int CTL_SWPOL_BIT = 0;
	localparam int CTL_EDIT_LSB  = 1;
	localparam int CTL_SUM_BIT   = 3;
	localparam int CTL_PWR_BIT   = 4;
	localparam int CTL_LIVE_BIT  = 5;
	localparam int CTL_STOP_LSB  = 6;
	localparam int CTL_METH_LSB  = 8;
	localparam int SRC_F1_LSB    = 0;
	localparam int SRC_F2_LSB    = 3;
	localparam int SRC_R1_LSB    = 6;
	localparam int SRC_R2_LSB    = 8;
	localparam int SRC_AIN1_LSB  = 10;
	localparam int SRC_AIN2_LSB  = 14;
	localparam int FRQ_HOLD_LSB  = 0;
	localparam int FRQ_MIN_LSB   = 8;
	localparam int TERM_FN_W     = 4;

	//==========================================================
	// Reset values and write masks
	localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
	localparam logic [31:0] RST_SOURCE  = 32'h0000_0040;
	localparam logic [31:0] RST_FREQCFG = 32'h0000_0005;
	localparam logic [31:0] RST_BRAKE   = 32'h0000_001e;
	localparam logic [31:0] RST_TERMFN  = 32'h0000_0000;
	localparam logic [31:0] MSK_CTRL    = 32'h0000_07ff;
	localparam logic [31:0] MSK_SOURCE  = 32'h0003_ffff;
	localparam logic [31:0] MSK_FREQCFG = 32'h00ff_ffff;

	//==========================================================
	// Codes
	localparam logic [2:0] FSRC_KEYPAD  = 3'h0;
	localparam logic [2:0] FSRC_ANALOG  = 3'h1;
	localparam logic [2:0] FSRC_UPDOWN  = 3'h2;
	localparam logic [2:0] FSRC_MODBUS  = 3'h3;
	localparam logic [2:0] FSRC_PULSE   = 3'h4;
	localparam logic [1:0] RSRC_KEYPAD  = 2'h0;
	localparam logic [1:0] RSRC_TERM    = 2'h1;
	localparam logic [1:0] RSRC_MODBUS  = 2'h2;
	localparam logic [3:0] FN_LOC_REM   = 4'h3;
	localparam logic [3:0] FN_SRC_SEL   = 4'h4;
	localparam logic [3:0] AIN_MAINFREQ = 4'h0;
	localparam logic [1:0] EDIT_NO_RUN  = 2'h0;
	localparam logic [1:0] EDIT_RUN_OK  = 2'h1;
	localparam logic [1:0] EDIT_NO_PROG = 2'h2;
	localparam logic [1:0] STOP_RAMP    = 2'h0;
	localparam logic [2:0] METH_CL_VEC  = 3'h3;
	localparam logic [2:0] METH_PM_CL   = 3'h5;
	localparam logic [2:0] METH_PM_OL   = 3'h4;
	localparam logic [6:0] BRK_CARR_LIM = 7'h1e;
	localparam logic [6:0] BRK_MAX      = 7'h64;
	localparam logic [7:0] HOLD_MAX     = 8'h64;

	//==========================================================
	// Timing
	localparam int CLK_KHZ        = 125000;
	localparam int BLINK_HALF_MS  = 500;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

endpackage : dcsa_pkg

// [dcsa_arbiter.sv]
// Command source arbiter and run interlock for a motor drive
`timescale 1ns/100ps
module dcsa_arbiter
	import dcsa_pkg::*;
#(
	parameter int FREQ_W       = 16,
	parameter int N_TERM       = 8,
	parameter int BLINK_CYCLES = BLINK_HALF_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata_q,
	// Command sources
	input  wire logic              local_remote_key,
	input  wire logic [N_TERM-1:0] term_in,
	input  wire logic              dip_switch_on,
	input  wire logic              run_keypad,
	input  wire logic              run_terminal,
	input  wire logic              run_modbus,
	input  wire logic              params_loaded,
	// Keypad programming
	input  wire logic              prog_req,
	input  wire logic              prog_monitor_grp,
	// Frequency sources
	input  wire logic [FREQ_W-1:0] freq_keypad,
	input  wire logic [FREQ_W-1:0] analog_in_one,
	input  wire logic [FREQ_W-1:0] analog_in_two,
	input  wire logic [FREQ_W-1:0] freq_updown,
	input  wire logic [FREQ_W-1:0] freq_modbus,
	input  wire logic [FREQ_W-1:0] freq_pulse,
	// Stop sequencer
	input  wire logic              stopping,
	input  wire logic [FREQ_W-1:0] output_freq,
	// Results
	output logic                   run_out_q,
	output logic      [FREQ_W-1:0] freq_ref_q,
	output logic                   remote_mode_q,
	output logic                   source_two_q,
	output logic                   prog_mode_q,
	output logic                   led_blink_q,
	output logic                   duplicate_source_fault_q,
	output logic                   analog_config_fault_q,
	output logic      [FREQ_W-1:0] hold_thresh_q,
	output logic                   dc_brake_q,
	output logic                   zero_hold_q,
	output logic                   carrier_low_q
);

	//==========================================================
	// Parameter checks
	if (FREQ_W < 16 || N_TERM < 1 || N_TERM > 8 || BLINK_CYCLES < 2) begin : g_bad
		$error("dcsa_arbiter: unsupported parameter values");
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	//==========================================================
	// Configuration registers
	logic [31:0] ctrl_q, src_q, frqcfg_q, brake_q, termfn_q;
	logic [31:0] status;
	logic [7:0]  hold_wr;
	logic [6:0]  brk_wr;

	assign hold_wr = (reg_wdata[FRQ_HOLD_LSB +: 8] > HOLD_MAX) ? HOLD_MAX
	                                                             : reg_wdata[FRQ_HOLD_LSB +: 8];
	assign brk_wr  = (reg_wdata > 32'(BRK_MAX)) ? BRK_MAX : reg_wdata[6:0];

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q   <= RST_CTRL;
			src_q    <= RST_SOURCE;
			frqcfg_q <= RST_FREQCFG;
			brake_q  <= RST_BRAKE;
			termfn_q <= RST_TERMFN;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_CTRL:    ctrl_q   <= reg_wdata & MSK_CTRL;
				OFS_SOURCE:  src_q    <= reg_wdata & MSK_SOURCE;
				OFS_FREQCFG: frqcfg_q <= {8'h00, reg_wdata[FRQ_MIN_LSB +: 16], hold_wr};
				OFS_BRAKE:   brake_q  <= {25'h0000000, brk_wr};
				OFS_TERMFN:  termfn_q <= reg_wdata;
				default:     ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_CTRL:    reg_rdata_q <= ctrl_q;
				OFS_SOURCE:  reg_rdata_q <= src_q;
				OFS_FREQCFG: reg_rdata_q <= frqcfg_q;
				OFS_BRAKE:   reg_rdata_q <= brake_q;
				OFS_TERMFN:  reg_rdata_q <= termfn_q;
				OFS_STATUS:  reg_rdata_q <= status;
				default:     reg_rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_q <= 32'h0000_0000;
		end
	end

	//==========================================================
	// Field views
	logic       sw_policy, sum_en, pwr_policy, live_policy;
	logic [1:0] edit_policy, stop_method, run_one_sel, run_two_sel;
	logic [2:0] ctl_method, freq_one_sel, freq_two_sel;
	logic [3:0] ain_one_fn, ain_two_fn;
	logic [6:0] brake_level;
	logic [FREQ_W-1:0] hold_freq, min_out_freq;

	assign sw_policy    = ctrl_q[CTL_SWPOL_BIT];
	assign edit_policy  = ctrl_q[CTL_EDIT_LSB +: 2];
	assign sum_en       = ctrl_q[CTL_SUM_BIT];
	assign pwr_policy   = ctrl_q[CTL_PWR_BIT];
	assign live_policy  = ctrl_q[CTL_LIVE_BIT];
	assign stop_method  = ctrl_q[CTL_STOP_LSB +: 2];
	assign ctl_method   = ctrl_q[CTL_METH_LSB +: 3];
	assign freq_one_sel = src_q[SRC_F1_LSB +: 3];
	assign freq_two_sel = src_q[SRC_F2_LSB +: 3];
	assign run_one_sel  = src_q[SRC_R1_LSB +: 2];
	assign run_two_sel  = src_q[SRC_R2_LSB +: 2];
	assign ain_one_fn   = src_q[SRC_AIN1_LSB +: 4];
	assign ain_two_fn   = src_q[SRC_AIN2_LSB +: 4];
	assign brake_level  = brake_q[6:0];
	assign hold_freq    = FREQ_W'(frqcfg_q[FRQ_HOLD_LSB +: 8]);
	assign min_out_freq = FREQ_W'(frqcfg_q[FRQ_MIN_LSB +: 16]);

	//==========================================================
	// Terminal function decode
	logic [N_TERM-1:0] fn_lr_vec, fn_src_vec;

	for (genvar t = 0; t < N_TERM; t++) begin : g_term
		assign fn_lr_vec[t]  = termfn_q[t*TERM_FN_W +: TERM_FN_W] == FN_LOC_REM;
		assign fn_src_vec[t] = termfn_q[t*TERM_FN_W +: TERM_FN_W] == FN_SRC_SEL;
	end

	//==========================================================
	// Source selection
	logic want_remote, remote_d, src_two_d, lr_allow;
	logic keep_remote_q, sw_seen_q, exempt_q;

	always_comb begin
		if (|fn_lr_vec) begin
			want_remote = ~|(fn_lr_vec & term_in);
		end else begin
			want_remote = local_remote_key ? ~remote_mode_q : remote_mode_q;
		end
	end

	assign lr_allow  = ~run_out_q | live_policy;
	assign remote_d  = lr_allow ? want_remote : remote_mode_q;
	assign src_two_d = (|fn_src_vec) & (|(fn_src_vec & term_in)) & ~dip_switch_on;

	always_ff @(posedge clk) begin
		if (reset) begin
			remote_mode_q <= 1'b1;
			source_two_q  <= 1'b0;
			sw_seen_q     <= 1'b0;
			exempt_q      <= 1'b0;
		end else begin
			remote_mode_q <= remote_d;
			source_two_q  <= src_two_d;
			sw_seen_q     <= (remote_d != remote_mode_q) | (src_two_d != source_two_q);
			exempt_q      <= (remote_d != remote_mode_q) & run_out_q;
		end
	end

	//==========================================================
	// Run command path
	logic [1:0] run_code;
	logic       remote_run, eff_run, edit_block, inh_set, inh_now, pu_set, run_gate;
	logic       inhibit_q, pwr_pending_q, pwr_inh_q;

	assign run_code   = source_two_q ? run_two_sel : run_one_sel;
	assign remote_run = (run_code == RSRC_KEYPAD) ? run_keypad :
	                    (run_code == RSRC_TERM)   ? run_terminal :
	                    (run_code == RSRC_MODBUS) ? run_modbus : 1'b0;
	assign eff_run    = (remote_mode_q | keep_remote_q) ? remote_run : run_keypad;

	always_ff @(posedge clk) begin
		if (reset) begin
			keep_remote_q <= 1'b0;
		end else if (remote_mode_q & ~remote_d & run_out_q) begin
			keep_remote_q <= 1'b1;
		end else if (remote_mode_q | ~run_out_q) begin
			keep_remote_q <= 1'b0;
		end
	end

	assign edit_block = prog_mode_q & (edit_policy != EDIT_RUN_OK)
	                    & (edit_policy != EDIT_NO_PROG);
	assign pu_set  = pwr_pending_q & params_loaded & remote_mode_q & remote_run
	                 & ~pwr_policy;
	assign inh_set = (sw_seen_q & ~exempt_q & ~sw_policy & eff_run) | pu_set;
	assign inh_now = inhibit_q | inh_set;
	assign run_gate = ~pwr_pending_q & ~edit_block & ~duplicate_source_fault_q
	                  & ~analog_config_fault_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			inhibit_q <= 1'b0;
		end else if (inh_set) begin
			inhibit_q <= 1'b1;
		end else if (~eff_run) begin
			inhibit_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pwr_pending_q <= 1'b1;
			pwr_inh_q     <= 1'b0;
		end else begin
			if (params_loaded) begin
				pwr_pending_q <= 1'b0;
			end
			if (pu_set) begin
				pwr_inh_q <= 1'b1;
			end else if (~inhibit_q) begin
				pwr_inh_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			run_out_q <= 1'b0;
		end else begin
			run_out_q <= eff_run & ~inh_now & run_gate;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prog_mode_q <= 1'b0;
		end else begin
			prog_mode_q <= prog_req & ~((edit_policy == EDIT_NO_PROG) & run_out_q
			                            & ~prog_monitor_grp);
		end
	end

	//==========================================================
	// Power-up blink
	logic [31:0] blink_cnt_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			blink_cnt_q <= 32'h0000_0000;
			led_blink_q <= 1'b0;
		end else if (~pwr_inh_q) begin
			blink_cnt_q <= 32'h0000_0000;
			led_blink_q <= 1'b0;
		end else if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
			blink_cnt_q <= 32'h0000_0000;
			led_blink_q <= ~led_blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
		end
	end

	//==========================================================
	// Frequency reference
	logic              both_analog;
	logic [FREQ_W-1:0] freq_one, freq_two, ain_pick;
	logic [FREQ_W:0]   freq_sum;

	assign both_analog = sum_en & (freq_one_sel == FSRC_ANALOG) & (freq_two_sel == FSRC_ANALOG);
	assign ain_pick    = (ain_one_fn == AIN_MAINFREQ) ? analog_in_one : analog_in_two;

	function automatic logic [FREQ_W-1:0] pick_freq(input logic [2:0] code,
	                                                input logic [FREQ_W-1:0] ain);
		unique case (code)
			FSRC_ANALOG: pick_freq = ain;
			FSRC_UPDOWN: pick_freq = freq_updown;
			FSRC_MODBUS: pick_freq = freq_modbus;
			FSRC_PULSE:  pick_freq = freq_pulse;
			default:     pick_freq = freq_keypad;
		endcase
	endfunction : pick_freq

	assign freq_one = pick_freq(freq_one_sel, both_analog ? analog_in_one : ain_pick);
	assign freq_two = pick_freq(freq_two_sel, both_analog ? analog_in_two : ain_pick);
	assign freq_sum = {1'b0, freq_one} + {1'b0, freq_two};

	always_ff @(posedge clk) begin
		if (reset) begin
			freq_ref_q <= '0;
		end else if (~remote_mode_q & ~keep_remote_q) begin
			freq_ref_q <= freq_keypad;
		end else if (sum_en) begin
			freq_ref_q <= freq_sum[FREQ_W] ? '1 : freq_sum[FREQ_W-1:0];
		end else begin
			freq_ref_q <= source_two_q ? freq_two : freq_one;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			duplicate_source_fault_q <= 1'b0;
			analog_config_fault_q    <= 1'b0;
		end else begin
			duplicate_source_fault_q <= sum_en & (freq_one_sel == freq_two_sel)
			                            & (freq_one_sel != FSRC_ANALOG);
			analog_config_fault_q    <= sum_en & (ain_one_fn == AIN_MAINFREQ)
			                            & (ain_two_fn == AIN_MAINFREQ) & ~both_analog;
		end
	end

	//==========================================================
	// Stop hold and brake
	logic brake_meth, hold_meth, below_thr;

	assign hold_meth  = (ctl_method == METH_CL_VEC) | (ctl_method == METH_PM_CL);
	assign brake_meth = (ctl_method < METH_CL_VEC) | (ctl_method == METH_PM_OL);
	assign below_thr  = stopping & (stop_method == STOP_RAMP) & (output_freq < hold_thresh_q);

	always_ff @(posedge clk) begin
		if (reset) begin
			hold_thresh_q <= '0;
			dc_brake_q    <= 1'b0;
			zero_hold_q   <= 1'b0;
			carrier_low_q <= 1'b0;
		end else begin
			hold_thresh_q <= (hold_freq < min_out_freq) ? min_out_freq : hold_freq;
			dc_brake_q    <= below_thr & brake_meth;
			zero_hold_q   <= below_thr & hold_meth;
			carrier_low_q <= brake_level > BRK_CARR_LIM;
		end
	end

	assign status = {20'h00000, carrier_low_q, zero_hold_q, dc_brake_q, analog_config_fault_q,
	                 duplicate_source_fault_q, led_blink_q, pwr_inh_q, inhibit_q,
	                 prog_mode_q, source_two_q, remote_mode_q, run_out_q};

	//==========================================================
	// Checks
	sequence s_switch_live;
		sw_seen_q && !exempt_q && eff_run;
	endsequence
	sequence s_run_dropped;
		inhibit_q && !inh_set ##0 !eff_run;
	endsequence

	a_switch_ignore: assert property ((s_switch_live and !sw_policy) |=> !run_out_q)
		else $error("switched-in run command not ignored");
	a_switch_accept: assert property ((s_switch_live and (sw_policy && !inhibit_q && run_gate))
	                                  |=> run_out_q)
		else $error("switched-in run command not accepted");
	a_edit_reject: assert property (prog_mode_q && edit_policy == EDIT_NO_RUN |=> !run_out_q)
		else $error("run accepted while programming");
	a_prog_block: assert property (edit_policy == EDIT_NO_PROG && run_out_q && !prog_monitor_grp
	                               |=> !prog_mode_q)
		else $error("programming entered while running");
	a_lr_frozen: assert property (!live_policy && run_out_q |=> $stable(remote_mode_q))
		else $error("local/remote changed while running");
	a_dup_fault: assert property (sum_en && freq_one_sel == freq_two_sel
	                              && freq_one_sel != FSRC_ANALOG |=> duplicate_source_fault_q)
		else $error("duplicate source fault missing");
	a_ain_fault: assert property (analog_config_fault_q |-> $past(sum_en) && $past(!both_analog))
		else $error("analog fault without cause");
	a_carrier_low: assert property (brake_level > BRK_CARR_LIM |=> carrier_low_q)
		else $error("carrier not lowered");
	a_thresh_floor: assert property (##1 hold_thresh_q >= $past(min_out_freq))
		else $error("threshold below minimum output frequency");
	a_inhibit_clear: assert property (s_run_dropped |=> !inhibit_q)
		else $error("inhibit held after run removed");
	a_powerup_blink: assert property (pu_set |=> pwr_inh_q && !run_out_q)
		else $error("power-up run not ignored");

endmodule : dcsa_arbiter

// [dcsa_far_side.sv]
// Far-side model: keypad, control terminals and Modbus master
`timescale 1ns/100ps
module dcsa_far_side (
	// Clock
	input  wire logic             clk,
	// Commands from the bench
	input  wire logic [2:0]       run_cmd,
	input  wire logic             key_cmd,
	input  wire logic [7:0]       term_cmd,
	input  wire logic [5:0][15:0] freq_cmd,
	// Levels toward the drive
	output logic                  run_keypad,
	output logic                  run_terminal,
	output logic                  run_modbus,
	output logic                  local_remote_key,
	output logic      [7:0]       term_in,
	output logic      [5:0][15:0] freq_out
);
	logic key_q;

	//==========================================================
	// Sources change just after an edge; key press is one pulse
	always_ff @(posedge clk) begin
		{run_modbus, run_terminal, run_keypad} <= run_cmd;
		key_q                                  <= key_cmd;
		local_remote_key                       <= key_cmd & ~key_q;
		term_in                                <= term_cmd;
		freq_out                               <= freq_cmd;
	end
endmodule : dcsa_far_side

// [test_drive_command_source_arbiter.sv]
// Self-checking testbench for the command source arbiter
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module test_drive_command_source_arbiter;
	import dcsa_pkg::*;
	logic             clk, reset, reg_wr, reg_rd, dip_switch_on, params_loaded;
	logic             prog_req, prog_monitor_grp, stopping, key_cmd;
	logic [7:0]       reg_addr, term_cmd;
	logic [31:0]      reg_wdata, rdat;
	logic [2:0]       run_cmd;
	logic [5:0][15:0] fcmd;
	logic [15:0]      output_freq, rnd;
	logic [1:0]       seen;
	wire  [31:0]      reg_rdata_q;
	wire  [5:0][15:0] fo;
	wire  [7:0]       term_in;
	wire  [15:0]      freq_ref_q, hold_thresh_q;
	wire              run_keypad, run_terminal, run_modbus, local_remote_key;
	wire              run_out_q, remote_mode_q, source_two_q, prog_mode_q, led_blink_q;
	wire              duplicate_source_fault_q, analog_config_fault_q;
	wire              dc_brake_q, zero_hold_q, carrier_low_q;
	int               err_total, n_checks;

	//==========================================================
	// Instances
	dcsa_far_side FAR (.clk, .run_cmd, .key_cmd, .term_cmd, .freq_cmd(fcmd), .run_keypad,
		.run_terminal, .run_modbus, .local_remote_key, .term_in, .freq_out(fo));
	dcsa_arbiter #(.BLINK_CYCLES(4)) DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata_q, .local_remote_key, .term_in, .dip_switch_on, .run_keypad,
		.run_terminal, .run_modbus, .params_loaded, .prog_req, .prog_monitor_grp,
		.freq_keypad(fo[0]), .analog_in_one(fo[1]), .analog_in_two(fo[2]),
		.freq_updown(fo[3]), .freq_modbus(fo[4]), .freq_pulse(fo[5]), .stopping,
		.output_freq, .run_out_q, .freq_ref_q, .remote_mode_q, .source_two_q, .prog_mode_q,
		.led_blink_q, .duplicate_source_fault_q, .analog_config_fault_q, .hold_thresh_q,
		.dc_brake_q, .zero_hold_q, .carrier_low_q);

	//==========================================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [31:0] src(input int f1, f2, r1, r2, a1, a2);
		return 32'((f1 << SRC_F1_LSB) | (f2 << SRC_F2_LSB) | (r1 << SRC_R1_LSB)
			| (r2 << SRC_R2_LSB) | (a1 << SRC_AIN1_LSB) | (a2 << SRC_AIN2_LSB));
	endfunction : src
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rdat = reg_rdata_q;
	endtask : rd
	task automatic press;
		key_cmd <= 1'b1;
		tick(2);
		key_cmd <= 1'b0;
		tick(6);
	endtask : press
	task automatic note(input string s);
		$display("Test %s done", s);
	endtask : note
	task automatic results;
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	//==========================================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	//==========================================================
	// Main sequence
	initial begin
		{reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 40'h0};
		{dip_switch_on, params_loaded, prog_req, prog_monitor_grp, stopping} = 5'h0;
		{key_cmd, term_cmd, fcmd, output_freq, seen} = '0;
		run_cmd = 3'b010;
		rnd = 16'd18;
		tick(12);
		reset <= 1'b0;
		rd(OFS_CTRL);    `CHK(rdat, RST_CTRL)
		rd(OFS_SOURCE);  `CHK(rdat, RST_SOURCE)
		rd(OFS_FREQCFG); `CHK(rdat, RST_FREQCFG)
		rd(OFS_BRAKE);   `CHK(rdat, RST_BRAKE)
		rd(8'h20);       `CHK(rdat, 32'h0)
		`CHK(remote_mode_q, 1'b1)
		note("reset");
		tick(1);
		params_loaded <= 1'b1;
		tick(6);
		`CHK(run_out_q, 1'b0)
		repeat (12) begin
			@(posedge clk);
			seen = seen | {led_blink_q, ~led_blink_q};
		end
		`CHK(seen, 2'b11)
		run_cmd <= 3'b000;
		tick(6);
		run_cmd <= 3'b010;
		tick(6);
		`CHK(run_out_q, 1'b1)
		`CHK(led_blink_q, 1'b0)
		note("power-up");
		press();
		`CHK(remote_mode_q, 1'b1)
		`CHK(run_out_q, 1'b1)
		wr(OFS_CTRL, 32'(1 << CTL_LIVE_BIT));
		press();
		`CHK(remote_mode_q, 1'b0)
		`CHK(run_out_q, 1'b1)
		press();
		`CHK(remote_mode_q, 1'b1)
		note("live local/remote");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_SOURCE, src(0, 0, 1, 2, 0, 0));
		wr(OFS_TERMFN, 32'(FN_SRC_SEL));
		run_cmd  <= 3'b110;
		term_cmd <= 8'h01;
		tick(6);
		`CHK(source_two_q, 1'b1)
		`CHK(run_out_q, 1'b0)
		run_cmd <= 3'b010;
		tick(6);
		run_cmd <= 3'b110;
		tick(6);
		`CHK(run_out_q, 1'b1)
		wr(OFS_CTRL, 32'(1 << CTL_SWPOL_BIT));
		term_cmd <= 8'h00;
		tick(6);
		`CHK(source_two_q, 1'b0)
		`CHK(run_out_q, 1'b1)
		for (int i = 0; i < 6; i++) begin
			wr(OFS_SOURCE, src(0, 0, i < 3 ? i : (i + 1) % 3, i < 3 ? (i + 1) % 3 : i - 3, 0, 0));
			term_cmd <= 8'(i / 3);
			run_cmd  <= 3'(1 << (i % 3));
			tick(6);
			`CHK(run_out_q, 1'b1)
			run_cmd <= 3'(7 ^ (1 << (i % 3)));
			tick(6);
			`CHK(run_out_q, 1'b0)
		end
		dip_switch_on <= 1'b1;
		tick(6);
		`CHK(source_two_q, 1'b0)
		note("source switch");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_SOURCE, RST_SOURCE);
		run_cmd  <= 3'b000;
		prog_req <= 1'b1;
		tick(6);
		`CHK(prog_mode_q, 1'b1)
		run_cmd <= 3'b010;
		tick(6);
		`CHK(run_out_q, 1'b0)
		wr(OFS_CTRL, 32'(EDIT_RUN_OK) << CTL_EDIT_LSB);
		run_cmd <= 3'b000;
		tick(6);
		run_cmd <= 3'b010;
		tick(6);
		`CHK(run_out_q, 1'b1)
		prog_req <= 1'b0;
		wr(OFS_CTRL, 32'(EDIT_NO_PROG) << CTL_EDIT_LSB);
		tick(6);
		prog_req <= 1'b1;
		tick(6);
		`CHK(prog_mode_q, 1'b0)
		prog_monitor_grp <= 1'b1;
		tick(6);
		`CHK(prog_mode_q, 1'b1)
		{prog_req, prog_monitor_grp, run_cmd} <= 5'h0;
		note("programming");
		wr(OFS_CTRL, 32'(1 << CTL_SUM_BIT));
		wr(OFS_SOURCE, src(3, 4, 1, 0, 5, 5));
		for (int k = 0; k < 24; k++) begin
			rnd = lfsr(rnd);
			fcmd[k % 6] <= rnd & 16'h3fff;
			if (k % 6 == 5) begin
				tick(6);
				`CHK(freq_ref_q, 16'(fcmd[4] + fcmd[5]))
				`CHK(duplicate_source_fault_q, 1'b0)
			end
		end
		press();
		`CHK(remote_mode_q, 1'b0)
		`CHK(freq_ref_q, fcmd[0])
		press();
		wr(OFS_SOURCE, src(3, 3, 1, 0, 5, 5));
		tick(6);
		`CHK(duplicate_source_fault_q, 1'b1)
		wr(OFS_SOURCE, src(1, 1, 1, 0, 5, 5));
		tick(6);
		`CHK(duplicate_source_fault_q, 1'b0)
		`CHK(freq_ref_q, 16'(fcmd[1] + fcmd[2]))
		wr(OFS_SOURCE, src(1, 1, 1, 0, 0, 0));
		tick(6);
		`CHK(analog_config_fault_q, 1'b0)
		wr(OFS_SOURCE, src(3, 4, 1, 0, 0, 0));
		tick(6);
		`CHK(analog_config_fault_q, 1'b1)
		note("superposition");
		wr(OFS_SOURCE, RST_SOURCE);
		wr(OFS_FREQCFG, 32'h0000_0005);
		tick(3);
		`CHK(hold_thresh_q, 16'h0005)
		wr(OFS_FREQCFG, 32'h0000_00c8);
		rd(OFS_FREQCFG); `CHK(rdat[7:0], HOLD_MAX)
		wr(OFS_FREQCFG, 32'h0000_1405);
		tick(3);
		`CHK(hold_thresh_q, 16'h0014)
		stopping    <= 1'b1;
		output_freq <= 16'h000a;
		for (int m = 0; m < 6; m++) begin
			wr(OFS_CTRL, 32'(m << CTL_METH_LSB));
			tick(6);
			`CHK(dc_brake_q, 1'(m != 3 && m != 5))
			`CHK(zero_hold_q, 1'(m == 3 || m == 5))
		end
		wr(OFS_CTRL, 32'(1 << CTL_STOP_LSB));
		tick(6);
		`CHK(dc_brake_q, 1'b0)
		wr(OFS_CTRL, 32'h0);
		output_freq <= 16'h001e;
		tick(6);
		`CHK(dc_brake_q, 1'b0)
		wr(OFS_BRAKE, 32'h1f);
		tick(3);
		`CHK(carrier_low_q, 1'b1)
		wr(OFS_BRAKE, 32'h1e);
		tick(3);
		`CHK(carrier_low_q, 1'b0)
		wr(OFS_BRAKE, 32'hc8);
		rd(OFS_BRAKE); `CHK(rdat[6:0], BRK_MAX)
		note("braking");
		wr(OFS_TERMFN, 32'(FN_LOC_REM) << TERM_FN_W);
		term_cmd <= 8'h02;
		tick(6);
		`CHK(remote_mode_q, 1'b0)
		term_cmd <= 8'h00;
		tick(6);
		`CHK(remote_mode_q, 1'b1)
		note("terminal local/remote");
		reset         <= 1'b1;
		params_loaded <= 1'b0;
		run_cmd       <= 3'b010;
		tick(12);
		reset <= 1'b0;
		wr(OFS_CTRL, 32'(1 << CTL_PWR_BIT));
		params_loaded <= 1'b1;
		tick(6);
		`CHK(run_out_q, 1'b1)
		`CHK(led_blink_q, 1'b0)
		note("power-up accept");
		results();
	end
endmodule : test_drive_command_source_arbiter
